// *** hdl/sapc_dev.sv ***
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RL1: select high floats the whole bus
// RL2: result on top twelve lines
// RL3: low four lines driven low when enabled
// RL4: byte select low gives upper byte
// RL5: read/convert falling with select low converts
// RL6: read/convert rising with select low enables bus
// RL7: select falling with read/convert low converts
// RL8: both low 40ns starts hold and conversion
// RL9: host convert pulse 40ns to 6us
// RL10: busy low from start until result stored
// RL11: convert commands ignored while busy low
// RL12: both low at busy rise restarts conversion
// RL13: track after conversion, space commands 10us
// RL14: select and read/convert combined as OR
// RL15: host sets other input 10ns earlier
// RL16: select tied low, read high enables bus
// RL17: two's complement, msb on top line
// RL18: mid-conversion reads give previous result
// RL19: after busy rises, bus gives new result
// RL20: conversion start floats the bus
// RL21: host may latch on busy rising
// RL22: bus enabled only read high, select low
// RL23: fixed cycle conversion, register before busy release
module sapc_dev
  import sapc_pkg::*;
#(
  parameter int CONV_CYC = SAPC_CONV_TIME_CYC,
  parameter int LOW_CYC = SAPC_CONV_MIN_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  sapc_if.dev link,
  // sample presented by the analog side, two's complement
  input wire logic [SAPC_RES_W-1:0] i_sample,
  input wire logic i_byte_mode,
  output logic o_tracking,
  output logic [SAPC_RES_W-1:0] o_result
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    SAPC_ST_IDLE = 3'b001,
    SAPC_ST_CONV = 3'b010,
    SAPC_ST_DONE = 3'b100
  } sapc_state_e;

  typedef struct packed {
    // two-flop synchronisers on the pins
    logic [1:0] sel_sync;
    logic [1:0] rc_sync;
    logic [1:0] byte_sync;
    sapc_state_e st;
    // cycles spent in the conversion
    logic [15:0] cnt;
    // cycles both lines have read low, saturating
    logic [15:0] low_cnt;
    // sample frozen at the start of the conversion
    logic [SAPC_RES_W-1:0] held;
    // output register, updated before busy is released
    logic [SAPC_RES_W-1:0] result;
    logic busy_n;
    // registered drive of the bus lines
    logic oe;
    logic [SAPC_BUS_W-1:0] dout;
  } sapc_dev_s;

  sapc_dev_s s_reg;
  sapc_dev_s s_next;

  // low count parks here, so a pair still low at busy release
  // qualifies at once
  localparam logic [15:0] LOW_SAT = 16'hffff;
  // last count of the conversion: one cycle stores the result,
  // the next releases busy
  localparam int CONV_LAST = CONV_CYC - 2;

  logic sel_n;
  logic rc;
  logic both_low;
  logic [SAPC_RES_W-1:0] word;

  assign sel_n = s_reg.sel_sync[1];
  assign rc = s_reg.rc_sync[1];
  // level OR: order of the two inputs does not matter
  assign both_low = !sel_n && !rc; // see RL14 see RL5 see RL7

  // ****************************************
  // bus layout
  // ****************************************
  // byte mode puts one byte on the top eight lines and leaves
  // the rest low, so an eight-line host needs no steering
  function automatic logic [SAPC_BUS_W-1:0] sapc_place(
    input logic [SAPC_RES_W-1:0] res,
    input logic byte_mode,
    input logic low_half
  );
    logic [SAPC_BUS_W-1:0] full;
    full = {res, {SAPC_PAD_W{1'b0}}}; // see RL2 see RL3 see RL17
    if (!byte_mode) begin
      return full;
    end
    if (!low_half) begin
      return {full[15:8], 8'h00}; // see RL4
    end
    return {full[7:0], 8'h00}; // see RL4
  endfunction : sapc_place

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // ****************************************
    // input synchronisers
    // ****************************************
    s_next.sel_sync = {s_reg.sel_sync[0], link.select_n};
    s_next.rc_sync = {s_reg.rc_sync[0], link.read_conv};
    s_next.byte_sync = {s_reg.byte_sync[0], link.byte_sel};
    // ****************************************
    // command qualifier
    // ****************************************
    if (both_low) begin
      if (s_reg.low_cnt != LOW_SAT) begin
        s_next.low_cnt = s_reg.low_cnt + 16'h0001;
      end
    end else begin
      s_next.low_cnt = 16'h0000;
    end
    // ****************************************
    // conversion sequence
    // ****************************************
    case (s_reg.st)
      SAPC_ST_IDLE: begin
        // both low long enough: hold and convert
        if (both_low && (32'(s_reg.low_cnt) + 1 >= LOW_CYC)) begin
          s_next.st = SAPC_ST_CONV; // see RL8
          // frozen here: later motion of the input is not seen
          s_next.held = i_sample;
          s_next.busy_n = 1'b0; // see RL10
          s_next.cnt = 16'h0000;
        end
      end

      SAPC_ST_CONV: begin
        // no exit on control lines: commands ignored, see RL11
        if (32'(s_reg.cnt) >= CONV_LAST) begin
          s_next.st = SAPC_ST_DONE;
          s_next.result = s_reg.held; // see RL23
        end else begin
          s_next.cnt = s_reg.cnt + 16'h0001;
        end
      end

      SAPC_ST_DONE: begin
        // result stored a cycle earlier; now release busy
        s_next.busy_n = 1'b1; // see RL10 see RL23
        s_next.st = SAPC_ST_IDLE;
        // a still-low pair restarts next cycle without a fresh
        // acquisition window, see RL12
        s_next.low_cnt = both_low ? LOW_SAT : 16'h0000;
      end

      default: begin
        s_next.st = SAPC_ST_IDLE;
      end
    endcase
    // ****************************************
    // bus contents
    // ****************************************
    // output enable from the current levels only
    s_next.oe = !sel_n && rc; // see RL22 see RL1 see RL6 see RL16 see RL20
    // result register shows previous value until update
    word = s_next.result; // see RL18 see RL19
    s_next.dout = sapc_place(word, i_byte_mode, s_reg.byte_sync[1]);
    // ****************************************
    // reset
    // ****************************************
    if (!i_nrst) begin
      s_next.sel_sync = 2'b11;
      s_next.rc_sync = 2'b11;
      s_next.byte_sync = 2'b00;
      s_next.st = SAPC_ST_IDLE;
      s_next.cnt = 16'h0000;
      s_next.low_cnt = 16'h0000;
      s_next.held = SAPC_RES_RST;
      s_next.result = SAPC_RES_RST;
      s_next.busy_n = 1'b1;
      s_next.oe = 1'b0;
      s_next.dout = 16'h0000;
    end
  end

  always_ff @(posedge i_clk) begin
    s_reg <= s_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.busy_n = s_reg.busy_n;
  assign link.bus_out = s_reg.dout;
  assign link.bus_oe = {SAPC_BUS_W{s_reg.oe}}; // see RL1 see RL3
  // tracking resumes once the conversion has ended
  assign o_tracking = s_reg.busy_n; // see RL13
  assign o_result = s_reg.result;
endmodule : sapc_dev
`default_nettype wire

// *** hdl/sapc_pkg.sv ***
package sapc_pkg;
  // ****************************************
  // bus layout
  // ****************************************
  localparam int SAPC_BUS_W = 16;
  localparam int SAPC_RES_W = 12;
  localparam int SAPC_PAD_W = 4;
  localparam int SAPC_BYTE_W = 8;
  localparam int SAPC_RES_LSB_POS = 4;
  localparam logic [11:0] SAPC_RES_RST = 12'h000;
  // ****************************************
  // timing
  // ****************************************
  localparam int SAPC_CLK_NS = 40;
  localparam int SAPC_CONV_MIN_NS = 40;
  localparam int SAPC_CONV_MAX_NS = 6000;
  localparam int SAPC_CONV_TIME_NS = 8000;
  localparam int SAPC_SPACING_NS = 10000;
  localparam int SAPC_SETUP_NS = 10;
  // least times round up, at least one cycle
  localparam int SAPC_CONV_MIN_CYC =
    (SAPC_CONV_MIN_NS + SAPC_CLK_NS - 1) / SAPC_CLK_NS;
  localparam int SAPC_CONV_TIME_CYC = SAPC_CONV_TIME_NS / SAPC_CLK_NS;
  localparam int SAPC_SPACING_CYC =
    (SAPC_SPACING_NS + SAPC_CLK_NS - 1) / SAPC_CLK_NS;
  localparam int SAPC_SETUP_CYC_RAW =
    (SAPC_SETUP_NS + SAPC_CLK_NS - 1) / SAPC_CLK_NS;
  localparam int SAPC_SETUP_CYC =
    (SAPC_SETUP_CYC_RAW < 1) ? 1 : SAPC_SETUP_CYC_RAW;
  // longest time rounds down
  localparam int SAPC_CONV_MAX_CYC = SAPC_CONV_MAX_NS / SAPC_CLK_NS;
endpackage : sapc_pkg

// *** hdl/sapc_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface sapc_if;
  logic select_n;
  logic read_conv;
  logic byte_sel;
  logic busy_n;
  logic [15:0] bus_out;
  logic [15:0] bus_oe;
  // bus as seen by the host; lines not driven read inverted, so a
  // read with the drivers off shows up as wrong data
  wire [15:0] bus_line;
  genvar g;
  for (g = 0; g < 16; g++) begin : g_res
    assign bus_line[g] = bus_oe[g] ? bus_out[g] : ~bus_out[g];
  end
  modport dev (
    input select_n,
    input read_conv,
    input byte_sel,
    output busy_n,
    output bus_out,
    output bus_oe
  );
  modport host (
    output select_n,
    output read_conv,
    output byte_sel,
    input busy_n,
    input bus_line
  );
endinterface : sapc_if
`default_nettype wire

// *** hdl/sapc_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module sapc_host
  import sapc_pkg::*;
#(
  parameter int PULSE_CYC = SAPC_CONV_MIN_CYC + 2,
  parameter int SPACE_CYC = SAPC_SPACING_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  sapc_if.host link,
  input wire logic i_start,
  input wire logic i_byte,
  output logic o_ready,
  output logic o_valid,
  output logic [SAPC_BUS_W-1:0] o_data
);
  typedef enum logic [3:0] {
    SAPC_H_IDLE = 4'b0001,
    SAPC_H_PULSE = 4'b0010,
    SAPC_H_WAIT = 4'b0100,
    SAPC_H_SPACE = 4'b1000
  } sapc_hst_e;

  typedef struct packed {
    logic [1:0] busy_sync;
    // synchronised busy one cycle later, for the edge
    logic busy_q;
    // busy seen low in this command
    logic seen;
    sapc_hst_e st;
    logic [15:0] cnt;
    logic sel_n;
    logic rc;
    logic byte_sel;
    logic valid;
    logic [SAPC_BUS_W-1:0] data;
  } sapc_host_s;

  sapc_host_s h_reg;
  sapc_host_s h_next;

  always_comb begin
    h_next = h_reg;
    h_next.busy_sync = {h_reg.busy_sync[0], link.busy_n};
    h_next.busy_q = h_reg.busy_sync[1];
    h_next.valid = 1'b0;
    case (h_reg.st)
      SAPC_H_IDLE: begin
        h_next.byte_sel = i_byte;
        if (i_start) begin
          // select goes low a cycle ahead, so read/convert starts it
          h_next.sel_n = 1'b0; // see RL15
          h_next.cnt = 16'h0000;
          h_next.st = SAPC_H_PULSE;
        end
      end
      SAPC_H_PULSE: begin
        h_next.cnt = h_reg.cnt + 16'h0001;
        h_next.rc = 1'b0;
        if (32'(h_reg.cnt) >= PULSE_CYC) begin
          // release before busy can rise, see RL9 see RL12
          h_next.rc = 1'b1;
          h_next.st = SAPC_H_WAIT;
        end
      end
      SAPC_H_WAIT: begin
        // counting on gives start-to-start spacing
        h_next.cnt = h_reg.cnt + 16'h0001;
        if (!h_reg.busy_sync[1]) begin
          h_next.seen = 1'b1;
        end
        // latch on busy rising, see RL21
        if (h_reg.busy_sync[1] && !h_reg.busy_q) begin
          h_next.data = link.bus_line;
          h_next.valid = 1'b1;
        end
        // deselect one cycle after the latch
        if (h_reg.seen && h_reg.busy_sync[1] && h_reg.busy_q) begin
          h_next.sel_n = 1'b1;
          h_next.seen = 1'b0;
          h_next.st = SAPC_H_SPACE;
        end
      end
      SAPC_H_SPACE: begin
        h_next.cnt = h_reg.cnt + 16'h0001;
        if (32'(h_reg.cnt) + 1 >= SPACE_CYC) begin
          h_next.st = SAPC_H_IDLE; // see RL13
        end
      end
      default: begin
        h_next.st = SAPC_H_IDLE;
      end
    endcase
    if (!i_nrst) begin
      h_next.busy_sync = 2'b11;
      h_next.busy_q = 1'b1;
      h_next.seen = 1'b0;
      h_next.st = SAPC_H_IDLE;
      h_next.cnt = 16'h0000;
      h_next.sel_n = 1'b1;
      h_next.rc = 1'b1;
      h_next.byte_sel = 1'b0;
      h_next.valid = 1'b0;
      h_next.data = 16'h0000;
    end
  end

  always_ff @(posedge i_clk) begin
    h_reg <= h_next;
  end

  assign link.select_n = h_reg.sel_n;
  assign link.read_conv = h_reg.rc;
  assign link.byte_sel = h_reg.byte_sel;
  assign o_ready = (h_reg.st == SAPC_H_IDLE);
  assign o_valid = h_reg.valid;
  assign o_data = h_reg.data;
endmodule : sapc_host
`default_nettype wire

// *** test/sapc_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module sapc_chk
  import sapc_pkg::*;
#(
  parameter int CONV_CYC = SAPC_CONV_TIME_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic select_n,
  input wire logic read_conv,
  input wire logic byte_sel,
  input wire logic busy_n,
  input wire logic [15:0] bus_out,
  input wire logic [15:0] bus_oe
);
  // ****
  // link checks
  // ****
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic rd;
  logic cv;
  logic [15:0] lo_reg;
  assign rd = !select_n && read_conv;
  assign cv = !select_n && !read_conv;
  // cycles spent converting, cleared while idle
  always_ff @(posedge i_clk) begin
    if (!i_nrst || busy_n) begin
      lo_reg <= 16'h0000;
    end else begin
      lo_reg <= lo_reg + 16'h0001;
    end
  end
  a_pad_low: assert property (
    |bus_oe[3:0] |-> bus_out[3:0] == 4'h0) else $error("pad not low");
  a_oe_whole: assert property (
    bus_oe == 16'h0000 || bus_oe == 16'hffff) else $error("split enable");
  a_sel_floats: assert property (
    select_n [*5] |-> bus_oe == 16'h0000) else $error("driven, no select");
  a_conv_floats: assert property (
    !read_conv [*5] |-> bus_oe == 16'h0000) else $error("driven in convert");
  a_read_drives: assert property (
    rd [*5] |-> bus_oe == 16'hffff) else $error("read not driven");
  a_oe_cause: assert property (
    |bus_oe |-> $past(rd, 1) || $past(rd, 2) || $past(rd, 3) || $past(rd, 4))
    else $error("enable without read");
  a_busy_cause: assert property (
    $fell(busy_n) |-> $past(cv, 2) || $past(cv, 3) || $past(cv, 4))
    else $error("busy without command");
  a_busy_len: assert property (
    $rose(busy_n) |-> lo_reg == 16'(CONV_CYC)) else $error("busy length");
  a_busy_hold: assert property (
    $fell(busy_n) |=> !busy_n [*8]) else $error("busy cut short");
  c_conv: cover property ($rose(busy_n));
  c_hi: cover property (|bus_oe && !byte_sel);
  c_lo: cover property (|bus_oe && byte_sel);
endmodule : sapc_chk
`default_nettype wire

// *** test/tb_sar_adc_parallel_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_sar_adc_parallel_control;
  localparam int CONV = 20;
  logic i_clk;
  logic i_nrst;
  logic [11:0] i_sample;
  logic i_byte_mode;
  logic i_start;
  logic i_byte;
  logic o_ready;
  logic o_valid;
  logic [15:0] o_data;
  logic o_tracking;
  logic [11:0] o_result;
  logic [11:0] last;
  int n_errors;
  int n_tests;
  sapc_if link ();
  sapc_dev #(.CONV_CYC(CONV)) sapc_dev_inst (.i_clk(i_clk),
    .i_nrst(i_nrst), .link(link.dev), .i_sample(i_sample),
    .i_byte_mode(i_byte_mode), .o_tracking(o_tracking),
    .o_result(o_result));
  sapc_host #(.SPACE_CYC(10)) sapc_host_inst (.i_clk(i_clk),
    .i_nrst(i_nrst), .link(link.host), .i_start(i_start),
    .i_byte(i_byte), .o_ready(o_ready), .o_valid(o_valid),
    .o_data(o_data));
  sapc_chk #(.CONV_CYC(CONV)) sapc_chk_inst (.i_clk(i_clk),
    .i_nrst(i_nrst), .select_n(link.select_n),
    .read_conv(link.read_conv), .byte_sel(link.byte_sel),
    .busy_n(link.busy_n), .bus_out(link.bus_out), .bus_oe(link.bus_oe));
  // ****
  // helpers
  // ****
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  function automatic logic [15:0] lay(input logic [11:0] r,
    input logic bm, input logic bs);
    if (!bm) return {r, 4'h0};
    return bs ? {r[3:0], 12'h000} : {r[11:4], 8'h00};
  endfunction : lay
  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conv(input logic [11:0] s, input logic bm,
    input logic bs);
    int k;
    @(posedge i_clk);
    i_sample <= s;
    i_byte_mode <= bm;
    i_byte <= bs;
    for (k = 0; k < 400 && o_ready !== 1'b1; k++) @(negedge i_clk);
    @(posedge i_clk);
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    for (k = 0; k < 50 && link.busy_n !== 1'b0; k++) @(negedge i_clk);
    @(posedge i_clk);
    // input moves on, the held sample must not
    i_sample <= ~s;
    repeat (10) @(negedge i_clk);
    chk("mid bus", link.bus_line, lay(last, bm, bs));
    chk("tracking", {15'h0000, o_tracking}, 16'h0000);
    for (k = 0; k < 100 && o_valid !== 1'b1; k++) @(negedge i_clk);
    chk("data", o_data, lay(s, bm, bs));
    chk("result", {4'h0, o_result}, {4'h0, s});
    repeat (8) @(negedge i_clk);
    chk("float", link.bus_oe, 16'h0000);
    chk("track", {15'h0000, o_tracking}, 16'h0001);
    last = s;
  endtask : conv
  // ****
  // scenarios
  // ****
  task automatic test_idle();
    @(negedge i_clk);
    chk("idle bus", link.bus_oe, 16'h0000);
    chk("idle busy", {15'h0000, link.busy_n}, 16'h0001);
    $display("test idle done");
  endtask : test_idle
  task automatic test_word();
    logic [11:0] codes [5] = '{12'h7ff, 12'h800, 12'hfff, 12'h000, 12'h5a3};
    foreach (codes[i]) conv(codes[i], 1'b0, 1'b0);
    $display("test word done");
  endtask : test_word
  task automatic test_byte();
    conv(12'ha5c, 1'b1, 1'b0);
    conv(12'h3c7, 1'b1, 1'b1);
    $display("test byte done");
  endtask : test_byte
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    i_nrst = 1'b0;
    i_sample = 12'h000;
    i_byte_mode = 1'b0;
    i_start = 1'b0;
    i_byte = 1'b0;
    n_errors = 0;
    n_tests = 0;
    last = sapc_pkg::SAPC_RES_RST;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    test_idle();
    test_word();
    test_byte();
    print_verdict();
  end
  // a hung handshake ends the run
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
endmodule : tb_sar_adc_parallel_control
`default_nettype wire
